// ===== hw/iacd_regs.vh
// Register offsets, field positions and reset values for the averaging block
`ifndef IACD_REGS_VH
`define IACD_REGS_VH

// Byte offsets on the register bus
`define IACD_OFS_CTRL 8'h00
`define IACD_OFS_STATUS 8'h04
`define IACD_OFS_AVG 8'h08
`define IACD_OFS_MEAS 8'h0C
`define IACD_OFS_REF 8'h10

// Control register fields
`define IACD_CTRL_TYPE_BIT 0
`define IACD_CTRL_COUNT_LSB 4
`define IACD_CTRL_COUNT_MSB 7
`define IACD_CTRL_CMP_BIT 8
`define IACD_CTRL_HOLD_LSB 12
`define IACD_CTRL_HOLD_MSB 14
`define IACD_CTRL_MASK 32'h0000_71F1
`define IACD_CTRL_RESET 32'h0000_0000

// Averaging types
`define IACD_TYPE_SIMPLE 1'h0
`define IACD_TYPE_MOVING 1'h1

// Sample count codes: count is two to the power of the code
`define IACD_COUNT_MAX 4'hA

// Timing hold modes
`define IACD_HOLD_NORMAL 3'h0
`define IACD_HOLD_SAMPLE 3'h1
`define IACD_HOLD_PEAK 3'h2
`define IACD_HOLD_BOTTOM 3'h3
`define IACD_HOLD_PP 3'h4

// Status register fields
`define IACD_STAT_REF_BIT 0
`define IACD_STAT_FULL_BIT 1
`define IACD_STAT_FILL_LSB 16

`endif

// ===== hw/iacd_compare.v
// Previous-average comparison stage: difference from a half-weighted reference
`default_nettype none

module iacd_compare (
	input wire clk_in,
	input wire rst_n_in,
	input wire clear_in,
	input wire enable_in,
	input wire in_valid_in,
	input wire [15:0] in_data_in,
	output reg out_valid_out,
	output reg [16:0] out_data_out,
	output reg [15:0] ref_out,
	output reg ref_valid_out
);

	wire [16:0] in_ext;
	wire [16:0] ref_ext;
	wire [16:0] half_sum;

	// Sign extension and reference update arithmetic
	assign in_ext = {in_data_in[15], in_data_in};
	assign ref_ext = {ref_out[15], ref_out};
	assign half_sum = in_ext + ref_ext;

	////////////////////////////////////////////////////////////////////////
	// Difference and reference register
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			out_valid_out <= 1'b0;
			out_data_out <= 17'h0_0000;
			ref_out <= 16'h0000;
			ref_valid_out <= 1'b0;
		end else if (clear_in) begin
			// Restart from the first-sample condition
			out_valid_out <= 1'b0;
			ref_out <= 16'h0000;
			ref_valid_out <= 1'b0;
		end else begin
			out_valid_out <= in_valid_in;
			if (in_valid_in) begin
				if (!enable_in) begin
					// Pass through untouched
					out_data_out <= in_ext;
					ref_out <= 16'h0000;
					ref_valid_out <= 1'b0;
				end else if (!ref_valid_out) begin
					// First value loads the reference, result zero
					out_data_out <= 17'h0_0000;
					ref_out <= in_data_in;
					ref_valid_out <= 1'b1;
				end else begin
					out_data_out <= in_ext - ref_ext;
					ref_out <= half_sum[16:1];
				end
			end
		end
	end

endmodule // iacd_compare

`default_nettype wire

// ===== hw/iacd_top.v
// Input averaging and previous-average change detection with Avalon-MM registers
`default_nettype none
`include "iacd_regs.vh"

// Register map, all words 32 bits wide
//   CTRL   0x00 read/write: averaging type, count code, compare enable, hold mode
//   STATUS 0x04 read only: reference loaded, window full, fill level
//   AVG    0x08 read only: last averaged value, sign-extended
//   MEAS   0x0C read only: last measurement after comparison, sign-extended
//   REF    0x10 read only: comparison reference, sign-extended
// Reserved control bits read back as zero
// Unmapped addresses read as zero, writes there are ignored
// Any change of type, count or compare enable restarts both stages
// A hold mode change alone keeps history and reference
// Count codes above the largest legal one act as the largest

module iacd_top (
	// Clock and reset
	input wire clk_in,
	input wire rst_n_in,
	// Register bus, one wait cycle per access
	input wire [7:0] avs_address_in,
	input wire avs_read_in,
	input wire avs_write_in,
	input wire [31:0] avs_writedata_in,
	input wire [3:0] avs_byteenable_in,
	output reg [31:0] avs_readdata_out,
	output reg avs_waitrequest_out,
	// Sample stream and external hold stage
	input wire sample_valid_in,
	input wire [15:0] sample_in,
	input wire hold_strobe_in,
	input wire [15:0] hold_value_in,
	// Averaged and compared results
	output reg avg_valid_out,
	output reg [15:0] avg_data_out,
	output wire meas_valid_out,
	output wire [16:0] meas_data_out
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	reg [31:0] ctrl_reg;
	wire [31:0] ctrl_next;
	wire [31:0] ctrl_mask;
	wire ctrl_wr;
	reg clear_reg;

	// Averaging state
	reg [25:0] sum_reg;
	reg [25:0] sum_next;
	reg [10:0] count_reg;
	reg [10:0] fill_reg;
	reg [9:0] wr_ptr_reg;
	reg [15:0] hist_mem [0:1023];
	reg [3:0] code_sel;
	reg [31:0] status_word;
	reg [31:0] read_word;

	// Bus and settings decode
	wire req;
	wire take;
	wire mode_moving;
	wire cmp_enable;
	wire [2:0] hold_mode;
	wire [3:0] code_raw;
	reg [10:0] n_val;

	// Datapath nets
	wire [9:0] old_ptr;
	wire [15:0] old_sample;
	wire [25:0] new_ext;
	wire [25:0] old_ext;
	wire window_full;
	wire [25:0] mean_wide;
	wire [15:0] mean_val;
	wire group_done;

	// Comparison path
	wire cmp_valid;
	wire [15:0] cmp_data;
	wire [15:0] ref_val;
	wire ref_valid;
	reg hold_discrete;

	////////////////////////////////////////////////////////////////////////
	// Register bus handshake

	// One wait cycle per access, answer on the second edge
	// Access walk, edges counted from the one that first sees the request
	//   edge 1: waitrequest drops, read data captured
	//   edge 2: write lands, master sees waitrequest low and releases
	//   edge 2, same edge: waitrequest high again for the next access
	assign req = avs_read_in | avs_write_in;
	assign take = req & ~avs_waitrequest_out;

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			avs_waitrequest_out <= 1'b1;
		end else if (req && avs_waitrequest_out) begin
			avs_waitrequest_out <= 1'b0;
		end else begin
			avs_waitrequest_out <= 1'b1;
		end
	end

	// Control write strobe, taken on the edge that ends the wait
	assign ctrl_wr = take & avs_write_in & (avs_address_in == `IACD_OFS_CTRL);
	assign ctrl_mask = `IACD_CTRL_MASK;

	// Control write per byte lane; reserved bits always read back as zero
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
			assign ctrl_next[lane*8 +: 8] = (ctrl_wr && avs_byteenable_in[lane]) ?
				(avs_writedata_in[lane*8 +: 8] & ctrl_mask[lane*8 +: 8]) :
				ctrl_reg[lane*8 +: 8];
		end
	endgenerate

	// Control register and settings-change clear
	// Clear starts high so the first edge after reset also restarts history
	// Only type, count and compare bits restart the datapath
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_reg <= `IACD_CTRL_RESET;
			clear_reg <= 1'b1;
		end else begin
			ctrl_reg <= ctrl_next;
			clear_reg <= (ctrl_next[`IACD_CTRL_CMP_BIT:0] !=
				ctrl_reg[`IACD_CTRL_CMP_BIT:0]);
		end
	end

	// Setting fields
	assign mode_moving = ctrl_reg[`IACD_CTRL_TYPE_BIT];
	assign cmp_enable = ctrl_reg[`IACD_CTRL_CMP_BIT];
	assign hold_mode = ctrl_reg[`IACD_CTRL_HOLD_MSB:`IACD_CTRL_HOLD_LSB];
	assign code_raw = ctrl_reg[`IACD_CTRL_COUNT_MSB:`IACD_CTRL_COUNT_LSB];

	// Count code clamped to the largest legal count
	// Keeps the shift and window pointer inside the history memory
	always @* begin
		if (code_raw > `IACD_COUNT_MAX) begin
			code_sel = `IACD_COUNT_MAX;
		end else begin
			code_sel = code_raw;
		end
	end

	// Window length for each count code
	always @* begin
		case (code_sel)
			4'h0: n_val = 11'h001;
			4'h1: n_val = 11'h002;
			4'h2: n_val = 11'h004;
			4'h3: n_val = 11'h008;
			4'h4: n_val = 11'h010;
			4'h5: n_val = 11'h020;
			4'h6: n_val = 11'h040;
			4'h7: n_val = 11'h080;
			4'h8: n_val = 11'h100;
			4'h9: n_val = 11'h200;
			default: n_val = 11'h400;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Status and read data

	always @* begin
		status_word = 32'h0000_0000;
		status_word[`IACD_STAT_REF_BIT] = ref_valid;
		status_word[`IACD_STAT_FULL_BIT] = window_full;
		status_word[`IACD_STAT_FILL_LSB +: 11] = fill_reg;
	end

	// Read mux, unmapped reads as zero
	// Results read back sign-extended to the bus width
	always @* begin
		case (avs_address_in)
			`IACD_OFS_CTRL: read_word = ctrl_reg;
			`IACD_OFS_STATUS: read_word = status_word;
			`IACD_OFS_AVG: read_word = {{16{avg_data_out[15]}}, avg_data_out};
			`IACD_OFS_MEAS: read_word = {{15{meas_data_out[16]}}, meas_data_out};
			`IACD_OFS_REF: read_word = {{16{ref_val[15]}}, ref_val};
			default: read_word = 32'h0000_0000;
		endcase
	end

	// Read data captured ahead of the answering edge
	// Captured while waitrequest is high, so it stands when waitrequest drops
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			avs_readdata_out <= 32'h0000_0000;
		end else if (avs_read_in && avs_waitrequest_out) begin
			avs_readdata_out <= read_word;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Averaging datapath

	// Oldest sample leaving the moving window
	// Count 1024 wraps the offset to zero: the write slot is the oldest
	assign old_ptr = wr_ptr_reg - n_val[9:0];
	assign old_sample = hist_mem[old_ptr];
	assign window_full = (fill_reg >= n_val);
	assign new_ext = {{10{sample_in[15]}}, sample_in};
	assign old_ext = window_full ? {{10{old_sample[15]}}, old_sample} : 26'h000_0000;
	assign group_done = (count_reg + 11'h001 == n_val);

	// Next running sum for either type
	always @* begin
		if (mode_moving) begin
			sum_next = sum_reg + new_ext - old_ext;
		end else begin
			sum_next = sum_reg + new_ext;
		end
	end

	// Power-of-two mean; count one leaves the sample as it is
	// Arithmetic shift rounds toward minus infinity
	assign mean_wide = $signed(sum_next) >>> code_sel;
	assign mean_val = mean_wide[15:0];

	// History memory of the moving window
	// No reset on the array; the fill level keeps stale entries out of the sum
	// Written in simple mode too, harmless since fill stays at zero there
	always @(posedge clk_in) begin
		if (sample_valid_in) begin
			hist_mem[wr_ptr_reg] <= sample_in;
		end
	end

	// Sum, group counter, fill level and result
	// Result timing
	//   simple: pulse one edge after the sample that completes a group
	//   moving: pulse one edge after each sample once the window is full
	//   compare stage adds one more edge
	// Clear has priority; a sample in the clear cycle is dropped
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sum_reg <= 26'h000_0000;
			count_reg <= 11'h000;
			fill_reg <= 11'h000;
			wr_ptr_reg <= 10'h000;
			avg_valid_out <= 1'b0;
			avg_data_out <= 16'h0000;
		end else if (clear_reg) begin
			// History forgotten, restart from the first sample
			sum_reg <= 26'h000_0000;
			count_reg <= 11'h000;
			fill_reg <= 11'h000;
			wr_ptr_reg <= 10'h000;
			avg_valid_out <= 1'b0;
		end else begin
			avg_valid_out <= 1'b0;
			if (sample_valid_in) begin
				wr_ptr_reg <= wr_ptr_reg + 10'h001;
				if (mode_moving) begin
					sum_reg <= sum_next;
					if (!window_full) begin
						fill_reg <= fill_reg + 11'h001;
					end
					// Result on every sample once the window holds N samples
					if (fill_reg + 11'h001 >= n_val) begin
						avg_valid_out <= 1'b1;
						avg_data_out <= mean_val;
					end
				end else if (group_done) begin
					// One result per completed group
					sum_reg <= 26'h000_0000;
					count_reg <= 11'h000;
					avg_valid_out <= 1'b1;
					avg_data_out <= mean_val;
				end else begin
					sum_reg <= sum_next;
					count_reg <= count_reg + 11'h001;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Confirmed value selection

	// Hold mode decode; unused codes behave as a discrete hold
	always @* begin
		case (hold_mode)
			`IACD_HOLD_NORMAL: hold_discrete = 1'b0;
			`IACD_HOLD_SAMPLE: hold_discrete = 1'b1;
			`IACD_HOLD_PEAK: hold_discrete = 1'b1;
			`IACD_HOLD_BOTTOM: hold_discrete = 1'b1;
			`IACD_HOLD_PP: hold_discrete = 1'b1;
			default: hold_discrete = 1'b1;
		endcase
	end

	// Normal: every averaged measurement; others: each new hold value only
	// The hold stage is fed from the averaged value, so averaging comes first
	// Strobe from the hold stage marks a newly produced value
	assign cmp_valid = hold_discrete ? hold_strobe_in : avg_valid_out;
	assign cmp_data = hold_discrete ? hold_value_in : avg_data_out;

	////////////////////////////////////////////////////////////////////////
	// Comparison stage

	// Clear shared with averaging so both stages restart together
	iacd_compare u_compare (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.clear_in(clear_reg),
		.enable_in(cmp_enable),
		.in_valid_in(cmp_valid),
		.in_data_in(cmp_data),
		.out_valid_out(meas_valid_out),
		.out_data_out(meas_data_out),
		.ref_out(ref_val),
		.ref_valid_out(ref_valid)
	);

endmodule // iacd_top

`default_nettype wire

// ===== verif/iacd_top_monitor.sv
// Property checker bound to the averaging block
`default_nettype none
module iacd_top_monitor (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic avs_waitrequest_out,
	input wire logic sample_valid_in,
	input wire logic [15:0] sample_in,
	input wire logic hold_strobe_in,
	input wire logic [15:0] hold_value_in,
	input wire logic avg_valid_out,
	input wire logic [15:0] avg_data_out,
	input wire logic meas_valid_out,
	input wire logic [16:0] meas_data_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] c_reg;
	// Shadow of the control word
	always_ff @(posedge clk_in or negedge rst_n_in)
		if (!rst_n_in) c_reg <= 16'h0000;
		else if (avs_write_in && !avs_waitrequest_out && avs_address_in == 8'h00)
			c_reg <= avs_writedata_in[15:0] & 16'h71F1;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	property p_ans;
		$rose(avs_read_in | avs_write_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out;
	endproperty
	a_ans: assert property (p_ans) else $error("bus answer late");
	property p_one;
		!avs_waitrequest_out |=> avs_waitrequest_out;
	endproperty
	a_one: assert property (p_one) else $error("wait low too long");
	property p_unm;
		avs_read_in && avs_waitrequest_out && avs_address_in > 8'h10 |=> avs_readdata_out == 0;
	endproperty
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	property p_pass;
		c_reg[8:0] == 9'h000 && sample_valid_in |=>
			avg_valid_out && avg_data_out == $past(sample_in);
	endproperty
	a_pass: assert property (p_pass) else $error("sample not passed");
	property p_off;
		c_reg[8] == 1'b0 && c_reg[14:12] == 3'h0 && avg_valid_out |=>
			meas_valid_out && $signed(meas_data_out) == $signed($past(avg_data_out));
	endproperty
	a_off: assert property (p_off) else $error("measure not passed");
	property p_hold;
		c_reg[14:12] != 3'h0 && meas_valid_out |-> $past(hold_strobe_in);
	endproperty
	a_hold: assert property (p_hold) else $error("measure without hold");
	property p_cause;
		avg_valid_out |-> $past(sample_valid_in);
	endproperty
	a_cause: assert property (p_cause) else $error("mean without sample");
	property p_grp;
		c_reg[0] == 1'b0 && c_reg[7:4] != 4'h0 && avg_valid_out |=> !avg_valid_out;
	endproperty
	a_grp: assert property (p_grp) else $error("group mean too soon");
endmodule // iacd_top_monitor
bind iacd_top iacd_top_monitor iacd_top_monitor_i (.*);
`default_nettype wire

// ===== verif/iacd_hold_model.sv
// Timing hold model: peak of each group of three means
`default_nettype none
module iacd_hold_model (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic avg_valid_in,
	input wire logic [15:0] avg_data_in,
	output logic hold_strobe_out,
	output logic [15:0] hold_value_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] n_reg;
	logic [15:0] pk_reg;
	wire logic [15:0] pk_next = (n_reg == 2'h0 || $signed(avg_data_in) > $signed(pk_reg)) ?
		avg_data_in : pk_reg;
	// Strobe carries a new hold value, else the line toggles between the last value and its complement
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			n_reg <= 2'h0;
			pk_reg <= 16'h0000;
			hold_strobe_out <= 1'b0;
			hold_value_out <= 16'h0000;
		end else begin
			hold_strobe_out <= 1'b0;
			hold_value_out <= ~hold_value_out;
			if (avg_valid_in) begin
				pk_reg <= pk_next;
				n_reg <= (n_reg == 2'h2) ? 2'h0 : n_reg + 2'h1;
				if (n_reg == 2'h2) begin
					hold_strobe_out <= 1'b1;
					hold_value_out <= pk_next;
				end
			end
		end
	end
endmodule // iacd_hold_model
`default_nettype wire

// ===== verif/iacd_top_tb.sv
// Self-checking bench for the averaging block
`default_nettype none
module iacd_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 0, rst_n_in = 0, rd = 0, wr = 0, sv = 0, wt, av, mv, hs;
	logic [7:0] ad = 0;
	logic [31:0] wd = 0, rq, rv;
	logic [15:0] sd = 0, hv, ag, v[8];
	logic [16:0] md, aq[$], mq[$];
	int n_fail = 0, checks = 0, seed = 6787;
	always #50 clk_in = ~clk_in;
	iacd_top iacd_top_i (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.avs_address_in(ad),
		.avs_read_in(rd),
		.avs_write_in(wr),
		.avs_writedata_in(wd),
		.avs_byteenable_in(4'hF),
		.avs_readdata_out(rq),
		.avs_waitrequest_out(wt),
		.sample_valid_in(sv),
		.sample_in(sd),
		.hold_strobe_in(hs),
		.hold_value_in(hv),
		.avg_valid_out(av),
		.avg_data_out(ag),
		.meas_valid_out(mv),
		.meas_data_out(md)
	);
	iacd_hold_model iacd_hold_model_i (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.avg_valid_in(av),
		.avg_data_in(ag),
		.hold_strobe_out(hs),
		.hold_value_out(hv)
	);
	// Gather every result pulse
	always @(posedge clk_in) begin
		if (av) aq.push_back({ag[15], ag});
		if (mv) mq.push_back(md);
	end
	task chk(input string s, input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s exp %h got %h", s, e, g);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		wr <= w;
		rd <= !w;
		ad <= a;
		wd <= d;
		do @(posedge clk_in); while (wt !== 1'b0);
		rv = rq;
		wr <= 0;
		rd <= 0;
		repeat (3) @(posedge clk_in);
	endtask
	task cfg(input logic [31:0] c);
		bus(1, 8'h00, c);
		aq = {};
		mq = {};
	endtask
	// Back-to-back samples, the first a corner value
	task send(input int n, input logic [15:0] c);
		for (int i = 0; i < n; i++) begin
			v[i] = i ? $random(seed) : c;
			@(posedge clk_in);
			sv <= 1;
			sd <= v[i];
		end
		@(posedge clk_in);
		sv <= 0;
		repeat (8) @(posedge clk_in);
	endtask
	function automatic logic [16:0] mean(input int s0, input int lg);
		int s = 0;
		for (int j = 0; j < (1 << lg); j++) s += $signed(v[j + s0]);
		return 17'(s >>> lg);
	endfunction
	function automatic logic [16:0] pk(input int s0);
		int x = $signed(v[s0]);
		for (int j = 1; j < 3; j++) if ($signed(v[s0 + j]) > x) x = $signed(v[s0 + j]);
		return 17'(x);
	endfunction
	task wrap_up;
		if (n_fail == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#1_000_000;
		n_fail++;
		wrap_up;
	end
	initial begin
		logic [16:0] e, r;
		repeat (12) @(posedge clk_in);
		rst_n_in <= 1;
		repeat (2) @(posedge clk_in);
		bus(0, 8'h00, 0);
		chk("ctrl reset", rv, 0);
		bus(0, 8'h40, 0);
		chk("unmapped", rv, 0);
		bus(1, 8'h00, 32'hFFFF_FFFF);
		bus(0, 8'h00, 0);
		chk("ctrl mask", rv, 32'h0000_71F1);
		// Plain pass, then difference from the running reference
		for (int m = 0; m < 2; m++) begin
			cfg(32'(m << 8));
			send(6, 16'h8000);
			chk("meas count", mq.size(), 6);
			for (int i = 0; i < 6; i++) begin
				e = {v[i][15], v[i]};
				chk("avg pass", aq[i], e);
				r = i ? r : e;
				chk("meas", mq[i], m ? 17'(e - r) : e);
				r = $signed(r + e) >>> 1;
			end
			if (m) begin
				bus(0, 8'h10, 0);
				chk("ref", rv, 32'($signed(r)));
				bus(0, 8'h04, 0);
				chk("status", rv, 32'h0000_0001);
				bus(0, 8'h08, 0);
				chk("avg reg", rv, 32'($signed(v[5])));
			end
		end
		// Simple groups of four, then moving window of two
		for (int m = 0; m < 2; m++) begin
			cfg(m ? 32'h0000_0011 : 32'h0000_0020);
			send(8, 16'h7FFF);
			chk("mean count", aq.size(), m ? 7 : 2);
			for (int k = 0; k < (m ? 7 : 2); k++) begin
				e = m ? mean(k, 1) : mean(4 * k, 2);
				chk("mean", aq[k], e);
				chk("meas mean", mq[k], e);
			end
		end
		// Every hold mode other than normal: only hold values reach the difference stage
		for (int h = 1; h < 5; h++) begin
			cfg(0);
			cfg(32'(h << 12) | 32'h0000_0100);
			send(6, 16'h8000);
			chk("hold count", mq.size(), 2);
			chk("first", mq[0], 0);
			chk("change", mq[1], 17'(pk(3) - pk(0)));
		end
		wrap_up;
	end
endmodule // iacd_top_tb
`default_nettype wire
